// >>> rtl/mpsel_top.sv
// mode decode and multi-purpose pin routing for the three-pll generator
//
// Functional notes
// - mode from manual bit and strap level
// - single-pll mode: bit one, strap floating
// - gp_in2..0 pick one of eight sets
// - single mode: gp_in3 suspend, gp_in5 ref
// - single mode: lock and clock loss outputs
// - sets 4..7 borrowed from pll1/pll2 groups
// - single mode: pll1 and pll2 fixed on config zero
// - stored bit picks post-divider setting
// - four divider and filter sets per pll
// - gp_in0/1 carry i2c or jtag lines
// - suspend high stops pll outputs
// - trst low resets boundary scan asynchronously
// - gp_in5 chooses reference clock source
// - gp_out0 tdo in jtag, else lock
// - filter resistor 0.3k plus 1k per code
// - zero cap 6pF plus 27.2pF per code
// - pole cap 1.3pF plus 0.75pF per code
// - pump current 5uA times two to code
// - all-pll mode: pin pairs pick sets
// - strap high enters i2c mode
// - strap low enters jtag mode
`timescale 1ns/100ps
module mpsel_top (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // mode control
   input wire logic manual_select_bit,
   input wire logic strap_sense_high,
   input wire logic strap_sense_low,
   // general pins and status sources
   input wire logic [5:0] gp_in,
   input wire logic lock_lost_flag,
   input wire logic primary_clock_lost_flag,
   input wire logic jtag_tdo,
   // stored pll configuration groups
   input mpsel_pkg::mpsel_cfg_t pll_cfg [mpsel_pkg::NUM_PLL]
      [mpsel_pkg::NUM_CFG],
   // mode and selection
   output mpsel_pkg::mpsel_mode_t mode,
   output logic [2:0] pll0_sel,
   output logic [1:0] pll1_sel,
   output logic [1:0] pll2_sel,
   // applied configuration per pll
   output mpsel_pkg::mpsel_cfg_t active_cfg [mpsel_pkg::NUM_PLL],
   output mpsel_pkg::mpsel_lf_t active_lf [mpsel_pkg::NUM_PLL],
   output logic [2:0] post_div_set_select,
   // pin functions
   output logic pll_suspend,
   output logic ref_source_select,
   output mpsel_pkg::mpsel_prog_t prog,
   output logic bst_reset_n,
   output logic gp_out0,
   output logic gp_out1
);
   import mpsel_pkg::*;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [GP_IN_W+1:0] pin_s1;
   logic [GP_IN_W+1:0] pin_s2;
   logic [GP_IN_W-1:0] gp_s;
   logic strap_h;
   logic strap_l;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else begin
         pin_s1 <= {strap_sense_high, strap_sense_low, gp_in};
         pin_s2 <= pin_s1;
      end
   end

   assign gp_s = pin_s2[GP_IN_W-1:0];
   assign strap_l = pin_s2[GP_IN_W];
   assign strap_h = pin_s2[GP_IN_W+1];

   // ------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------
   function automatic mpsel_mode_t decode_mode(input logic hi,
                                               input logic lo,
                                               input logic man);
      mpsel_mode_t m;
      m = MODE_ALL;
      if (hi && !lo)
         m = MODE_I2C;
      else if (lo && !hi)
         m = MODE_JTAG;
      else if (man)
         m = MODE_SINGLE;
      else
         m = MODE_ALL;
      return m;
   endfunction

   mpsel_mode_t next_mode;
   // both senses active is a pad fault; treat it as floating
   assign next_mode = decode_mode(strap_h, strap_l, manual_select_bit);

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         mode <= MODE_ALL;
      else
         mode <= next_mode;
   end

   // ------------------------------------------------------------
   // set selection from the general pins
   // ------------------------------------------------------------
   // programming modes hold the last index so entering or leaving them
   // does not switch configuration under a running pll, except pll0 sets 4..7, which fall back to pll0 groups 0..3 in those modes
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pll0_sel <= '0;
      end else begin
         case (next_mode)
            MODE_SINGLE: pll0_sel <= gp_s[2:0];
            MODE_ALL: pll0_sel <= {1'b0, gp_s[1:0]};
            default: pll0_sel <= pll0_sel;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pll1_sel <= '0;
         pll2_sel <= '0;
      end else begin
         case (next_mode)
            MODE_SINGLE: begin
               pll1_sel <= '0;
               pll2_sel <= '0;
            end
            MODE_ALL: begin
               pll1_sel <= gp_s[3:2];
               pll2_sel <= gp_s[5:4];
            end
            default: begin
               pll1_sel <= pll1_sel;
               pll2_sel <= pll2_sel;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // configuration steering
   // ------------------------------------------------------------
   mpsel_cfg_t next_cfg [NUM_PLL];
   mpsel_lf_t next_lf [NUM_PLL];

   always_comb begin
      next_cfg[0] = pll_cfg[0][pll0_sel[1:0]];
      if (mode == MODE_SINGLE && pll0_sel[2]) begin
         // upper four sets live in the spare groups 2 and 3
         if (pll0_sel[1])
            next_cfg[0] = pll_cfg[2][{1'b1, pll0_sel[0]}];
         else
            next_cfg[0] = pll_cfg[1][{1'b1, pll0_sel[0]}];
      end
      next_cfg[1] = pll_cfg[1][pll1_sel];
      next_cfg[2] = pll_cfg[2][pll2_sel];
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PLL; gi++) begin : g_pll
         mpsel_lf_decode u_lf (
            .cfg(next_cfg[gi]),
            .lf(next_lf[gi])
         );

         // a new index reaches the pll with no register write
         always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               active_cfg[gi] <= CFG_RESET;
               active_lf[gi] <= LF_RESET;
            end else begin
               active_cfg[gi] <= next_cfg[gi];
               active_lf[gi] <= next_lf[gi];
            end
         end

         assign post_div_set_select[gi] =
            active_cfg[gi].post_div_set_select;
      end
   endgenerate

   // ------------------------------------------------------------
   // suspend and reference select
   // ------------------------------------------------------------
   // in all-pll mode gp_in5 is an index bit, so the primary reference
   // stays selected and suspend is unavailable; gp_in4 is ignored
   // in single-pll and i2c modes
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pll_suspend <= 1'b0;
         ref_source_select <= 1'b0;
      end else begin
         pll_suspend <= (next_mode != MODE_ALL)
            && gp_s[PIN_SUSPEND];
         ref_source_select <= (next_mode != MODE_ALL)
            && gp_s[PIN_REF_SEL];
      end
   end

   // ------------------------------------------------------------
   // programming port routing
   // ------------------------------------------------------------
   // sampling at sys_clk limits the serial clocks to well below 25 MHz
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         prog <= PROG_IDLE;
      end else begin
         prog <= PROG_IDLE;
         if (next_mode == MODE_I2C) begin
            prog.i2c_data_pin <= gp_s[PIN_SDA_TDI];
            prog.i2c_clock_pin <= gp_s[PIN_SCL_TCK];
         end
         if (next_mode == MODE_JTAG) begin
            prog.tdi <= gp_s[PIN_SDA_TDI];
            prog.tck <= gp_s[PIN_SCL_TCK];
            prog.tms <= gp_s[PIN_TMS];
         end
      end
   end

   // trst must act with no clock, so it bypasses the synchroniser
   assign bst_reset_n = (mode != MODE_JTAG) || gp_in[PIN_TRST];

   // ------------------------------------------------------------
   // general outputs
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         gp_out0 <= 1'b0;
         gp_out1 <= 1'b0;
      end else begin
         gp_out0 <= (mode == MODE_JTAG) ? jtag_tdo
                                        : lock_lost_flag;
         gp_out1 <= primary_clock_lost_flag;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence strap_high_s;
      strap_h && !strap_l;
   endsequence

   sequence strap_low_s;
      strap_l && !strap_h;
   endsequence

   sequence strap_float_s;
      strap_h == strap_l;
   endsequence

   sequence all_steady_s;
      (next_mode == MODE_ALL)[*2];
   endsequence

   i2c_mode_a: assert property (strap_high_s |=> mode == MODE_I2C)
      else $error("strap high did not give i2c mode");

   jtag_mode_a: assert property (strap_low_s |=> mode == MODE_JTAG)
      else $error("strap low did not give jtag mode");

   single_mode_a: assert property (
      strap_float_s ##0 manual_select_bit |=> mode == MODE_SINGLE)
      else $error("single-pll mode not entered");

   single_index_a: assert property (
      next_mode == MODE_SINGLE |=> pll0_sel == $past(gp_in[2:0], 3))
      else $error("pll0 index does not follow pins");

   pair_index_a: assert property (all_steady_s |=>
      pll2_sel == $past(gp_in[5:4], 3) && pll1_sel == $past(gp_in[3:2], 3))
      else $error("pll1 or pll2 index does not follow pins");

   fixed_pll12_a: assert property (
      mode == MODE_SINGLE |-> pll1_sel == '0 && pll2_sel == '0)
      else $error("pll1 or pll2 left config zero");

   borrow_set_a: assert property (
      mode == MODE_SINGLE && pll0_sel == 3'h6
      |=> active_cfg[0] == $past(pll_cfg[2][2]))
      else $error("set six not taken from pll2 group two");

   apply_set_a: assert property (
      mode == MODE_ALL |=> active_cfg[1] == $past(pll_cfg[1][pll1_sel]))
      else $error("selected pll1 set not applied");

   tdo_route_a: assert property (
      mode == MODE_JTAG |=> gp_out0 == $past(jtag_tdo))
      else $error("gp_out0 does not carry tdo");

   suspend_a: assert property (
      next_mode == MODE_SINGLE && gp_s[PIN_SUSPEND] |=> pll_suspend)
      else $error("suspend pin did not suspend pll");

   pump_code_a: assert property (
      $past(reset_n) |-> active_lf[0].pump_ua
         == (LF_PUMP_BASE << active_cfg[0].pump_current_code))
      else $error("pump current does not match code");

   trst_a: assert property (
      mode == MODE_JTAG && !gp_in[PIN_TRST] |-> !bst_reset_n)
      else $error("trst low did not reset boundary scan");

endmodule

// >>> rtl/mpsel_pkg.sv
// shared constants and types for the multi-purpose pin mode select block
package mpsel_pkg;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int NUM_PLL = 3;
   localparam int NUM_CFG = 4;
   localparam int GP_IN_W = 6;
   // storage location of the manual select bit in the device map
   localparam logic [7:0] MANUAL_SEL_ADDR = 8'h04;

   // ------------------------------------------------------------
   // general input pin positions
   // ------------------------------------------------------------
   localparam int PIN_SDA_TDI = 0;
   localparam int PIN_SCL_TCK = 1;
   localparam int PIN_TMS = 2;
   localparam int PIN_SUSPEND = 3;
   localparam int PIN_TRST = 4;
   localparam int PIN_REF_SEL = 5;

   // ------------------------------------------------------------
   // loop filter scaling (units: 100 ohm, 100 fF, 10 fF, 1 uA)
   // ------------------------------------------------------------
   localparam logic [7:0] LF_RES_BASE = 8'h03;
   localparam logic [7:0] LF_RES_STEP = 8'h0a;
   localparam logic [12:0] LF_ZCAP_BASE = 13'h003c;
   localparam logic [12:0] LF_ZCAP_STEP = 13'h0110;
   localparam logic [10:0] LF_PCAP_BASE = 11'h082;
   localparam logic [10:0] LF_PCAP_STEP = 11'h04b;
   localparam logic [9:0] LF_PUMP_BASE = 10'h005;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      MODE_SINGLE = 4'b0001,
      MODE_ALL = 4'b0010,
      MODE_I2C = 4'b0100,
      MODE_JTAG = 4'b1000
   } mpsel_mode_t;

   typedef struct packed {
      logic [7:0] pre_scaler;
      logic [11:0] feedback_div;
      logic [3:0] zero_resistor_code;
      logic [3:0] zero_cap_code;
      logic [3:0] pole_cap_code;
      logic [2:0] pump_current_code;
      logic post_div_set_select;
   } mpsel_cfg_t;

   typedef struct packed {
      logic [7:0] res_100ohm;
      logic [12:0] zcap_100ff;
      logic [10:0] pcap_10ff;
      logic [9:0] pump_ua;
   } mpsel_lf_t;

   typedef struct packed {
      logic i2c_data_pin;
      logic i2c_clock_pin;
      logic tdi;
      logic tck;
      logic tms;
   } mpsel_prog_t;

   localparam mpsel_cfg_t CFG_RESET = '0;
   localparam mpsel_lf_t LF_RESET = '0;
   // idle levels while a programming port is not selected
   localparam mpsel_prog_t PROG_IDLE = 5'h1d;

endpackage

// >>> rtl/mpsel_lf_decode.sv
// loop filter code to component value decoder
`timescale 1ns/100ps
module mpsel_lf_decode (
   // selected configuration
   input mpsel_pkg::mpsel_cfg_t cfg,
   // decoded component values
   output mpsel_pkg::mpsel_lf_t lf
);
   import mpsel_pkg::*;

   always_comb begin
      lf = LF_RESET;
      // 0.3 k to 15.3 k in 1 k steps
      lf.res_100ohm = LF_RES_BASE
         + LF_RES_STEP * {4'h0, cfg.zero_resistor_code};
      lf.zcap_100ff = LF_ZCAP_BASE
         + LF_ZCAP_STEP * {9'h000, cfg.zero_cap_code};
      lf.pcap_10ff = LF_PCAP_BASE
         + LF_PCAP_STEP * {7'h00, cfg.pole_cap_code};
      lf.pump_ua = LF_PUMP_BASE << cfg.pump_current_code;
   end

endmodule

// >>> tb/mpsel_host_model.sv
// board controller model that drives the general pins and the strap
`timescale 1ns/100ps
module mpsel_host_model (
   // clock
   input wire logic sys_clk,
   // requested pin levels from the bench
   input wire logic req_manual,
   input wire logic [1:0] req_strap,
   input wire logic [5:0] req_gp,
   input wire logic [2:0] req_status,
   // pins towards the device
   output logic manual_select_bit,
   output logic strap_sense_high,
   output logic strap_sense_low,
   output logic [5:0] gp_in,
   output logic lock_lost_flag,
   output logic primary_clock_lost_flag,
   output logic jtag_tdo
);
   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   // the board holds its pins through reset, so nothing here is reset
   initial begin
      manual_select_bit = 1'b0;
      {strap_sense_high, strap_sense_low} = 2'h0;
      gp_in = 6'h00;
      {jtag_tdo, primary_clock_lost_flag, lock_lost_flag} = 3'h0;
   end
   // strap code 0 leaves the pad floating: neither sense line is set
   always @(posedge sys_clk) begin
      manual_select_bit <= req_manual;
      strap_sense_high <= (req_strap == 2'h1);
      strap_sense_low <= (req_strap == 2'h2);
      gp_in <= req_gp;
      {jtag_tdo, primary_clock_lost_flag, lock_lost_flag} <= req_status;
   end
endmodule

// >>> tb/mpsel_top_tb.sv
// self-checking bench for the multi-purpose pin mode select block
`timescale 1ns/100ps
module mpsel_top_tb;
   import mpsel_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic req_manual = 1'b0;
   logic [1:0] req_strap = 2'h0;
   logic [5:0] req_gp = 6'h00;
   logic [2:0] req_status = 3'h0;
   logic manual_select_bit, strap_sense_high, strap_sense_low;
   logic [5:0] gp_in;
   logic lock_lost_flag, primary_clock_lost_flag, jtag_tdo;
   mpsel_cfg_t pll_cfg [NUM_PLL][NUM_CFG];
   mpsel_mode_t mode;
   logic [2:0] pll0_sel, post_div_set_select;
   logic [1:0] pll1_sel, pll2_sel;
   mpsel_cfg_t active_cfg [NUM_PLL];
   mpsel_lf_t active_lf [NUM_PLL];
   logic pll_suspend, ref_source_select, bst_reset_n, gp_out0, gp_out1;
   mpsel_prog_t prog;
   logic [5:0] g;
   logic [2:0] st, old;
   logic [5:0] pat [2] = '{6'h2b, 6'h14};
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
   n_fail++; $display("wrong value at %0t: got %h want %h", $time, \
   got, exp); end end

   initial begin
      forever #10 sys_clk = ~sys_clk;
   end

   mpsel_host_model u_mpsel_host_model (.sys_clk(sys_clk),
      .req_manual(req_manual), .req_strap(req_strap), .req_gp(req_gp),
      .req_status(req_status), .manual_select_bit(manual_select_bit),
      .strap_sense_high(strap_sense_high), .strap_sense_low(strap_sense_low),
      .gp_in(gp_in), .lock_lost_flag(lock_lost_flag),
      .primary_clock_lost_flag(primary_clock_lost_flag), .jtag_tdo(jtag_tdo));

   mpsel_top u_mpsel_top (.sys_clk(sys_clk), .reset_n(reset_n),
      .manual_select_bit(manual_select_bit),
      .strap_sense_high(strap_sense_high), .strap_sense_low(strap_sense_low),
      .gp_in(gp_in), .lock_lost_flag(lock_lost_flag),
      .primary_clock_lost_flag(primary_clock_lost_flag), .jtag_tdo(jtag_tdo),
      .pll_cfg(pll_cfg), .mode(mode), .pll0_sel(pll0_sel),
      .pll1_sel(pll1_sel), .pll2_sel(pll2_sel), .active_cfg(active_cfg),
      .active_lf(active_lf), .post_div_set_select(post_div_set_select),
      .pll_suspend(pll_suspend), .ref_source_select(ref_source_select),
      .prog(prog), .bst_reset_n(bst_reset_n), .gp_out0(gp_out0),
      .gp_out1(gp_out1));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // every group differs, so a wrong group index cannot match by chance
   function automatic mpsel_cfg_t mk_cfg(int p, int c);
      mpsel_cfg_t r;
      r.pre_scaler = 8'(16 * p + c + 1);
      r.feedback_div = 12'(256 * p + 7 * c + 5);
      r.zero_resistor_code = 4'(4 * p + c + 3);
      r.zero_cap_code = 4'(3 * c + p + 1);
      r.pole_cap_code = 4'(15 - c - 4 * p);
      r.pump_current_code = 3'(c + 2 * p);
      r.post_div_set_select = 1'((c + p) % 2);
      return r;
   endfunction

   function automatic mpsel_lf_t lf_of(mpsel_cfg_t c);
      mpsel_lf_t r;
      r.res_100ohm = LF_RES_BASE + LF_RES_STEP * {4'h0, c.zero_resistor_code};
      r.zcap_100ff = LF_ZCAP_BASE + LF_ZCAP_STEP * {9'h000, c.zero_cap_code};
      r.pcap_10ff = LF_PCAP_BASE + LF_PCAP_STEP * {7'h00, c.pole_cap_code};
      r.pump_ua = LF_PUMP_BASE << c.pump_current_code;
      return r;
   endfunction

   // pins land two edges after the call; returns one edge after that
   task automatic drive_pins(logic man, logic [1:0] strap, logic [5:0] gp,
      logic [2:0] stat);
      @(posedge sys_clk);
      req_manual <= man;
      req_strap <= strap;
      req_gp <= gp;
      req_status <= stat;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   task automatic settle();
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   task automatic chk_pll(int p, mpsel_cfg_t exp);
      `CHK(active_cfg[p], exp)
      `CHK(active_lf[p], lf_of(exp))
      `CHK(post_div_set_select[p], exp.post_div_set_select)
   endtask

   task automatic close_out();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ------------------------------------------------------------
   // hang guard: the whole run needs about 140 cycles
   // ------------------------------------------------------------
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 1000) begin
         n_fail++;
         close_out();
      end
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      // stored groups never pick a disabled post-divider setting
      for (int p = 0; p < NUM_PLL; p++)
         for (int c = 0; c < NUM_CFG; c++)
            pll_cfg[p][c] = mk_cfg(p, c);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK(mode, MODE_ALL)
      `CHK(prog, PROG_IDLE)
      `CHK(bst_reset_n, 1'b1)
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         g = {i[0], i[1], ~i[0], 3'(i)};
         st = 3'(i);
         drive_pins(1'b1, 2'h0, g, st);
         settle();
         `CHK(mode, MODE_SINGLE)
         `CHK(pll0_sel, 3'(i))
         `CHK({pll1_sel, pll2_sel}, 4'h0)
         `CHK(pll_suspend, g[3])
         `CHK(ref_source_select, g[5])
         `CHK({gp_out1, gp_out0}, st[1:0])
         chk_pll(0, i < 4 ? pll_cfg[0][i] : pll_cfg[i/2-1][i%2+2]);
         chk_pll(1, pll_cfg[1][0]);
         chk_pll(2, pll_cfg[2][0]);
      end
      for (int v = 0; v < 4; v++) begin
         g = {2'(v), 2'(v + 1), 2'(3 - v)};
         st = 3'(v + 2);
         old = pll0_sel;
         drive_pins(1'b0, 2'h0, g, st);
         if (v > 0)
            `CHK(pll0_sel, old)
         settle();
         `CHK(mode, MODE_ALL)
         `CHK(pll0_sel, {1'b0, g[1:0]})
         `CHK({pll1_sel, pll2_sel}, {g[3:2], g[5:4]})
         `CHK({pll_suspend, ref_source_select}, 2'h0)
         `CHK({gp_out1, gp_out0}, st[1:0])
         for (int p = 0; p < NUM_PLL; p++)
            chk_pll(p, pll_cfg[p][g[2 * p +: 2]]);
      end
      for (int k = 0; k < 2; k++) begin
         g = pat[k];
         drive_pins(k[0], 2'h1, g, 3'h1);
         settle();
         `CHK(mode, MODE_I2C)
         `CHK({pll0_sel, pll1_sel, pll2_sel}, 7'h03)
         `CHK({prog.i2c_data_pin, prog.i2c_clock_pin}, {g[0], g[1]})
         `CHK({pll_suspend, ref_source_select}, {g[3], g[5]})
         `CHK(gp_out0, 1'b1)
         `CHK(bst_reset_n, 1'b1)
         drive_pins(k[0], 2'h2, g, 3'h6);
         settle();
         `CHK(mode, MODE_JTAG)
         `CHK({prog.tdi, prog.tck, prog.tms}, {g[0], g[1], g[2]})
         `CHK({gp_out1, gp_out0}, 2'h3)
         `CHK({pll_suspend, ref_source_select}, {g[3], g[5]})
         `CHK(bst_reset_n, g[4])
         @(posedge sys_clk);
         req_gp <= g ^ 6'h10;
         @(posedge sys_clk);
         #1;
         `CHK(bst_reset_n, ~g[4])
      end
      close_out();
   end
endmodule
